/* File: src/ocp_cfg.svh */
/*
 Holds the register map, field positions and reset values of the
 compare channel. Assumes inclusion by bare name from src/.
*/
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OCP_OFS_CON1 12'h000
`define OCP_OFS_PRI 12'h004
`define OCP_OFS_SEC 12'h008
`define OCP_OFS_PER 12'h00C
`define OCP_OFS_CON2 12'h010
`define OCP_OFS_STAT 12'h014

// ----------------------------------------
// Control one fields
// ----------------------------------------
`define OCP_B_IDLE 13
`define OCP_F_TSEL 12:10
`define OCP_F_FEN 9:7
`define OCP_F_FLT 6:4
`define OCP_B_TRMD 3
`define OCP_F_MODE 2:0
`define OCP_CON1_MASK 16'h3FFF

// ----------------------------------------
// Control two fields
// ----------------------------------------
`define OCP_B_FEXIT 15
`define OCP_B_FLVL 14
`define OCP_B_INV 12
`define OCP_B_TRIG 7
`define OCP_B_TRUN 6
`define OCP_F_SYNC 4:0
`define OCP_CON2_MASK 16'hD0DF
`define OCP_CON2_RST 16'h000C
`define OCP_SYNC_SELF 5'h1F

`endif

/* File: src/ocp_channel.sv */
/*
 Holds one output compare / PWM channel with an APB register slave.
 Assumes time base ticks and idle from logic on clk; fault pins and
 comparator outputs arrive asynchronously.
*/
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ocp_cfg.svh"

// What this block does
// (RULE_01) PWM compares use hidden shadow copies
// (RULE_02) PWM period is period value plus one
// (RULE_03) Duty copies latch only at period end
// (RULE_04) All zero values keep output low
// (RULE_05) Secondary above period keeps output high
// (RULE_06) Software selects self sync, synchronous mode
// (RULE_07) Timer prescaler tick clocks the counter
// (RULE_08) Idle-stop bit halts channel in idle
// (RULE_09) Time base code picks clock source
// (RULE_10) Three enable bits arm fault inputs
// (RULE_11) Enabled faults set sticky status flags
// (RULE_12) Fault bits act only in PWM
// (RULE_13) Comparator fault chosen by channel group
// (RULE_14) Trigger flag cleared by match optionally
// (RULE_15) Code 111 centre, 110 edge PWM
// (RULE_16) Code 101 toggles on alternating matches
// (RULE_17) Code 100 makes one single pulse
// (RULE_18) Code 011 toggles on every primary match
// (RULE_19) Codes 010/001 start high/low, then flip
// (RULE_20) Code 000 disables the channel
// (RULE_21) Fault ends at new period, policy
// (RULE_22) Fault drives output to fault level
// (RULE_23) Invert bit inverts the output
// (RULE_24) Edge PWM high at start, low at duty
module ocp_channel
	import ocp_pkg::*;
#(
	parameter int CHANNEL_INDEX = 1
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [4:0]  timeBaseTick,
	input  wire logic        cpuIdle,
	input  wire logic [2:0]  comparatorOut,
	input  wire logic        faultPinA,
	input  wire logic        faultPinB,
	output var  logic        channelOutputPin
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int CMP_IDX = (CHANNEL_INDEX - 1) / 3; // Group
	ocp_word_t   con1_r;     // Control one
	ocp_word_t   con2_r;     // Control two
	ocp_word_t   pri_r;      // Primary compare value
	ocp_word_t   sec_r;      // Secondary compare value
	ocp_word_t   per_r;      // Timer period value
	ocp_word_t   priSh_r;    // Shadow copies
	ocp_word_t   secSh_r;
	ocp_word_t   perSh_r;
	ocp_word_t   cnt_r;      // Channel internal counter
	logic        out_r;      // Compare output state
	logic        phase_r;    // Waiting for secondary match
	logic        done_r;     // Single pulse finished
	logic        fault_r;    // Fault state
	logic [4:0]  syncA_r;    // Synchroniser stages
	logic [4:0]  syncB_r;
	logic [31:0] rdata;
	logic        hit;
	logic        wrEn;
	ocp_mode_e   mode;
	logic        pwm;
	logic        tick;
	logic        run;
	logic        step;
	logic        hold;
	logic        selfSync;
	logic        perEnd;
	logic        matchP;
	logic        matchS;
	logic [2:0]  faultSrc;
	logic [2:0]  fltSet;
	logic        pwmOn;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Answer one cycle after setup; clkEn low stalls the bus too
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (clkEn)
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata  <= rdata;
		end
	end

	// Read mux; unmapped offsets read zero and flag an error
	always_comb
	begin
		hit   = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr)
			`OCP_OFS_CON1: rdata[15:0] = con1_r;
			`OCP_OFS_PRI:  rdata[15:0] = pri_r;
			`OCP_OFS_SEC:  rdata[15:0] = sec_r;
			`OCP_OFS_PER:  rdata[15:0] = per_r;
			`OCP_OFS_CON2: rdata[15:0] = con2_r;
			`OCP_OFS_STAT: rdata[17:0] = {fault_r, channelOutputPin, cnt_r};
			default:       hit = 1'b0;
		endcase
	end

	// Write strobe at the completing access edge only
	assign wrEn = psel && penable && pready && pwrite && clkEn;

	// ----------------------------------------
	// Data registers
	// ----------------------------------------
	// Software may write these at any time
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pri_r <= 16'h0000;
			sec_r <= 16'h0000;
			per_r <= 16'h0000;
		end
		else if (wrEn)
		begin
			if (paddr == `OCP_OFS_PRI)
				pri_r <= pwdata[15:0];
			if (paddr == `OCP_OFS_SEC)
				sec_r <= pwdata[15:0];
			if (paddr == `OCP_OFS_PER)
				per_r <= pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	assign mode = ocp_mode_e'(con1_r[`OCP_F_MODE]);
	assign pwm  = (mode == OCP_PWM_E) || (mode == OCP_PWM_C);

	// Fault flags are sticky; a hardware set beats a software clear
	always_ff @(posedge clk)
	begin
		if (rst)
			con1_r <= 16'h0000;
		else if (clkEn)
		begin
			if (wrEn && paddr == `OCP_OFS_CON1)
				con1_r <= pwdata[15:0] & `OCP_CON1_MASK;
			con1_r[`OCP_F_FLT] <= fltSet | ((wrEn && paddr == `OCP_OFS_CON1) ?
				pwdata[6:4] : con1_r[`OCP_F_FLT]); // see RULE_11
		end
	end

	// Trigger running flag: match clear is optional, software wins
	always_ff @(posedge clk)
	begin
		if (rst)
			con2_r <= `OCP_CON2_RST;
		else if (clkEn)
		begin
			if (con1_r[`OCP_B_TRMD] && matchS)
				con2_r[`OCP_B_TRUN] <= 1'b0; // see RULE_14
			if (wrEn && paddr == `OCP_OFS_CON2)
				con2_r <= pwdata[15:0] & `OCP_CON2_MASK;
		end
	end

	// ----------------------------------------
	// Fault input synchroniser
	// ----------------------------------------
	// Two stages; only the second stage is read by logic
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			syncA_r <= 5'h00;
			syncB_r <= 5'h00;
		end
		else if (clkEn)
		begin
			syncA_r <= {faultPinB, faultPinA, comparatorOut};
			syncB_r <= syncA_r;
		end
	end

	// Comparator picked by channel group of three
	assign faultSrc = {syncB_r[CMP_IDX], syncB_r[4], syncB_r[3]}; // see RULE_13

	// Armed sources set flags in PWM modes only
	assign fltSet = {3{pwm}} & con1_r[`OCP_F_FEN] & faultSrc; // see RULE_10 RULE_12

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	// Codes 0 to 4 take prescaler outputs, code 7 ticks every clock; never counter outputs
	always_comb
	begin
		unique case (con1_r[`OCP_F_TSEL])
			3'h7:       tick = 1'b1;            // see RULE_09
			3'h4:       tick = timeBaseTick[0]; // see RULE_07
			3'h3:       tick = timeBaseTick[4];
			3'h2:       tick = timeBaseTick[3];
			3'h1:       tick = timeBaseTick[2];
			3'h0:       tick = timeBaseTick[1];
			3'h5, 3'h6: tick = 1'b0;            // Reserved: no clock
		endcase
	end

	// Idle-stop halts everything that counts
	assign run      = clkEn && !(con1_r[`OCP_B_IDLE] && cpuIdle); // see RULE_08
	assign step     = run && tick && (mode != OCP_OFF);
	assign selfSync = (con2_r[`OCP_F_SYNC] == `OCP_SYNC_SELF) && !con2_r[`OCP_B_TRIG];
	assign hold     = con2_r[`OCP_B_TRIG] && !con2_r[`OCP_B_TRUN];
	assign matchP   = step && (cnt_r == pri_r);
	assign matchS   = step && (cnt_r == sec_r);

	// PWM always wraps on the shadow period; compare wraps if self-synced
	assign perEnd = step && (pwm ? (cnt_r == perSh_r) // see RULE_02
		: (selfSync && cnt_r == per_r)); // see RULE_06

	// Counter: held clear when disabled or awaiting a trigger
	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_r <= 16'h0000;
		else if (clkEn && (mode == OCP_OFF || hold))
			cnt_r <= 16'h0000; // see RULE_20
		else if (step)
			cnt_r <= perEnd ? 16'h0000 : cnt_r + 16'h0001;
	end

	// ----------------------------------------
	// Shadow copies
	// ----------------------------------------
	// Outside PWM they track live values, so PWM starts coherent
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			priSh_r <= 16'h0000;
			secSh_r <= 16'h0000;
			perSh_r <= 16'h0000;
		end
		else if (clkEn && (!pwm || perEnd))
		begin
			priSh_r <= pri_r; // see RULE_01 RULE_03
			secSh_r <= sec_r;
			perSh_r <= per_r;
		end
	end

	// ----------------------------------------
	// Compare modes
	// ----------------------------------------
	// Writing control one re-arms the initial level and single shots
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			out_r   <= 1'b0;
			phase_r <= 1'b0;
			done_r  <= 1'b0;
		end
		else if (clkEn && wrEn && paddr == `OCP_OFS_CON1)
		begin
			out_r   <= (pwdata[2:0] == OCP_SS_HI); // see RULE_19
			phase_r <= 1'b0;
			done_r  <= 1'b0;
		end
		else if (clkEn)
		begin
			unique case (mode)
				OCP_OFF:
					out_r <= 1'b0;
				OCP_SS_LO:
					if (matchP)
						out_r <= 1'b1; // see RULE_19
				OCP_SS_HI:
					if (matchP)
						out_r <= 1'b0; // see RULE_19
				OCP_TOGGLE:
					if (matchP)
						out_r <= !out_r; // see RULE_18
				OCP_DC_SS, OCP_DC_RUN:
					if (!done_r && !phase_r && matchP)
					begin
						out_r   <= 1'b1;
						phase_r <= 1'b1;
					end
					else if (!done_r && phase_r && matchS)
					begin
						out_r   <= 1'b0; // see RULE_16 RULE_17
						phase_r <= 1'b0;
						done_r  <= (mode == OCP_DC_SS);
					end
				OCP_PWM_E, OCP_PWM_C:
					out_r <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// PWM and fault
	// ----------------------------------------
	// Edge: high from period start until duty; centre: between values
	always_comb
	begin
		if (secSh_r > perSh_r)
			pwmOn = 1'b1; // see RULE_05
		else if (mode == OCP_PWM_E)
			pwmOn = cnt_r < secSh_r; // see RULE_24 RULE_04
		else
			pwmOn = (cnt_r >= priSh_r) && (cnt_r < secSh_r); // see RULE_15
	end

	// Fault exits at a period start once no source is active and, if FEXIT is set, the enabled flags are cleared; at once outside PWM
	always_ff @(posedge clk)
	begin
		if (rst)
			fault_r <= 1'b0;
		else if (clkEn)
		begin
			if (!pwm)
				fault_r <= 1'b0;
			else if (|fltSet)
				fault_r <= 1'b1;
			else if (perEnd && (!con2_r[`OCP_B_FEXIT]
				|| !(|(con1_r[`OCP_F_FEN] & con1_r[`OCP_F_FLT]))))
				fault_r <= 1'b0; // see RULE_21
		end
	end

	// Registered pin; invert applies last in every mode
	always_ff @(posedge clk)
	begin
		if (rst)
			channelOutputPin <= 1'b0;
		else if (clkEn)
			channelOutputPin <= con2_r[`OCP_B_INV] ^ (pwm ? (fault_r ? // see RULE_23
				con2_r[`OCP_B_FLVL] : pwmOn) : out_r); // see RULE_22
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_period_wrap: assert property ( // see RULE_02
		pwm && perEnd |=> cnt_r == 16'h0000)
		else $error("counter did not wrap at period end");
	chk_shadow_load: assert property ( // see RULE_03
		clkEn && pwm && perEnd |=> secSh_r == $past(sec_r))
		else $error("duty shadow not loaded at period end");
	chk_shadow_hold: assert property ( // see RULE_01
		clkEn && pwm && !perEnd |=> $stable(secSh_r) && $stable(perSh_r))
		else $error("shadow changed inside a period");
	chk_full_duty: assert property ( // see RULE_05
		clkEn && pwm && !fault_r && secSh_r > perSh_r |=>
		channelOutputPin != $past(con2_r[`OCP_B_INV]))
		else $error("full duty output not high");
	chk_zero_duty: assert property ( // see RULE_04
		clkEn && mode == OCP_PWM_E && !fault_r && secSh_r == 16'h0000
		&& perSh_r == 16'h0000 |=> channelOutputPin == $past(con2_r[`OCP_B_INV]))
		else $error("zero duty output not low");
	chk_fault_level: assert property ( // see RULE_22
		clkEn && pwm && fault_r |=> channelOutputPin ==
		($past(con2_r[`OCP_B_FLVL]) ^ $past(con2_r[`OCP_B_INV])))
		else $error("fault level not driven");
	chk_idle_halt: assert property ( // see RULE_08
		clkEn && con1_r[`OCP_B_IDLE] && cpuIdle && !hold |=> $stable(cnt_r))
		else $error("counter moved in idle");
	chk_off_quiet: assert property ( // see RULE_20
		clkEn && mode == OCP_OFF |=> cnt_r == 16'h0000
		&& channelOutputPin == $past(con2_r[`OCP_B_INV]))
		else $error("disabled channel active");
	chk_flag_sticky: assert property ( // see RULE_11
		clkEn && fltSet[0] |=> con1_r[4])
		else $error("fault flag not set");
	chk_off_mode_flag: assert property ( // see RULE_12
		!pwm |-> fltSet == 3'h0 && !fault_r ##0 1'b1 or $past(pwm))
		else $error("fault acted outside PWM");

	cov_pwm_period: cover property (mode == OCP_PWM_E && perEnd);
	cov_fault_entry: cover property (pwm && !fault_r ##1 fault_r);
	cov_single_shot: cover property (mode == OCP_DC_SS && !done_r ##1 done_r);

endmodule : ocp_channel
`default_nettype wire

/* File: src/ocp_pkg.sv */
/*
 Holds the types of the compare channel.
 Assumes nothing of its surroundings.
*/
package ocp_pkg;

	// Output mode codes
	typedef enum logic [2:0]
	{
		OCP_OFF    = 3'h0,
		OCP_SS_LO  = 3'h1,
		OCP_SS_HI  = 3'h2,
		OCP_TOGGLE = 3'h3,
		OCP_DC_SS  = 3'h4,
		OCP_DC_RUN = 3'h5,
		OCP_PWM_E  = 3'h6,
		OCP_PWM_C  = 3'h7
	} ocp_mode_e;

	// One 16-bit data word
	typedef logic [15:0] ocp_word_t;

endpackage : ocp_pkg

/* File: testbench/ocp_far_model.sv */
/*
 Far-side model: timer prescaler ticks, the three comparator outputs and the two fault pins.
 Assumes the bench requests fault levels on the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ocp_far_model
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [2:0] cmpReq,
	input  wire logic       pinAReq,
	input  wire logic       pinBReq,
	output var  logic [4:0] timeBaseTick,
	output var  logic [2:0] comparatorOut,
	output var  logic       faultPinA,
	output var  logic       faultPinB
);
	// ----------------------------------------
	// Prescalers
	// ----------------------------------------
	logic [2:0] div_r [5];  // Timer k divides by k+2 so rates differ
	// Pulse once per division, at the timer's own rollover
	always_ff @(posedge clk)
		for (int k = 0; k < 5; k++)
		begin
			div_r[k] <= (rst || div_r[k] == 3'(k + 1)) ? 3'h0 : div_r[k] + 3'h1;
			timeBaseTick[k] <= !rst && div_r[k] == 3'(k + 1);
		end
	// Faults are plain active-high levels
	always_ff @(posedge clk)
	begin
		comparatorOut <= cmpReq;
		faultPinA <= pinAReq;
		faultPinB <= pinBReq;
	end
endmodule : ocp_far_model
`default_nettype wire

/* File: testbench/output_compare_pwm_channel_tb.sv */
/*
 Bench for the compare channel: APB master and scenario tasks.
 Assumes the far-side model supplies ticks and fault levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ocp_cfg.svh"
module output_compare_pwm_channel_tb;
	import ocp_pkg::*;
	logic        clk = 0, rst = 1, cpuIdle = 0, fA = 0, fB = 0;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, pin, pinA, pinB;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [4:0]  tick;
	logic [2:0]  cmp, fC = 3'h0;
	int          fail_count = 0, checks = 0, cyc = 0, hi, ch, ri;
	localparam int RT[8] = '{20, 15, 12, 10, 30, 0, 0, 60};  // Rises in 240 cycles
	localparam int MC[6] = '{0, 0, 0, 8, 0, 16};  // Changes in 32 cycles
	localparam int MF[6] = '{0, 1, 0, -1, 0, -1};  // Final level, -1 skips
	always #2 clk = ~clk;
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			test_done();
		end
	end
	ocp_channel #(.CHANNEL_INDEX(1)) i_dut (.clk(clk), .rst(rst), .clkEn(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timeBaseTick(tick), .cpuIdle(cpuIdle), .comparatorOut(cmp),
		.faultPinA(pinA), .faultPinB(pinB), .channelOutputPin(pin));
	ocp_far_model i_far (.clk(clk), .rst(rst), .cmpReq(fC), .pinAReq(fA),
		.pinBReq(fB), .timeBaseTick(tick), .comparatorOut(cmp),
		.faultPinA(pinA), .faultPinB(pinB));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// One APB transfer; holds everything until pready is seen high
	task xf(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : xf
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	// Counts high cycles, changes and rising edges of the output
	task watch(input int n);
		logic p;
		p = pin;
		hi = 0;
		ch = 0;
		ri = 0;
		repeat (n)
		begin
			@(posedge clk);
			hi += int'(pin === 1'b1);
			ch += int'(pin !== p);
			ri += int'(pin === 1'b1 && p === 1'b0);
			p = pin;
		end
	endtask : watch
	task vals(input logic [15:0] p, s, r, c2);
		xf(1, `OCP_OFS_PRI, p);
		xf(1, `OCP_OFS_SEC, s);
		xf(1, `OCP_OFS_PER, r);
		xf(1, `OCP_OFS_CON2, c2);
	endtask : vals
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		xf(0, `OCP_OFS_CON1, 0);
		chk("con1", rd, 0);
		xf(0, `OCP_OFS_CON2, 0);
		chk("con2", rd, 32'h0000_000C);
		xf(0, 12'h018, 0);
		chk("unmapped err", {31'h0, er}, 1);
	endtask : t_reset
	task t_base;
		vals(1, 2, 3, 16'h001F);
		for (int c = 0; c < 8; c++)
		begin
			xf(1, `OCP_OFS_CON1, 16'(c << 10) | 16'h0006);
			wt(30);
			watch(240);
			chk("rises", ri, RT[c]);
		end
		chk("edge highs", hi, 120);
	endtask : t_base
	task duty(input logic [15:0] p, s, r, m, c2, input int e);
		vals(p, s, r, c2);
		xf(1, `OCP_OFS_CON1, 16'h1C00 | m);
		wt(30);
		watch(240);
		chk("highs", hi, e);
	endtask : duty
	task t_modes;
		vals(1, 2, 3, 16'h001F);
		for (int m = 0; m < 6; m++)
		begin
			xf(1, `OCP_OFS_CON1, 16'h1C00 | 16'(m));
			wt(12);
			watch(32);
			chk("toggles", ch, MC[m]);
			if (MF[m] >= 0)
				chk("level", {31'h0, pin}, MF[m]);
		end
	endtask : t_modes
	task t_idle;
		xf(1, `OCP_OFS_CON1, 16'h3C06);
		cpuIdle <= 1;
		wt(2);
		watch(40);
		chk("idle halt", ch, 0);
		xf(1, `OCP_OFS_CON1, 16'h1C06);
		wt(20);
		watch(40);
		chk("idle run", ri, 10);
		cpuIdle <= 0;
	endtask : t_idle
	task flags(input string n, input logic [2:0] e);
		wt(10);
		xf(0, `OCP_OFS_CON1, 0);
		chk(n, rd[6:4], e);
	endtask : flags
	task t_fault;
		vals(0, 0, 3, 16'hC01F);
		xf(1, `OCP_OFS_CON1, 16'h1E86);
		fB <= 1;
		flags("pin b off", 0);
		fB <= 0;
		fC <= 3'h2;
		flags("other group", 0);
		fC <= 3'h1;
		flags("cmp flag", 3'h4);
		fC <= 3'h0;
		fA <= 1;
		flags("pin a flag", 3'h5);
		chk("fault level", {31'h0, pin}, 1);
		fA <= 0;
		wt(20);
		xf(0, `OCP_OFS_STAT, 0);
		chk("fault held", rd[17], 1);
		xf(1, `OCP_OFS_CON1, 16'h1E86);
		wt(20);
		xf(0, `OCP_OFS_STAT, 0);
		chk("fault over", rd[17], 0);
		xf(1, `OCP_OFS_CON1, 16'h1E83);
		fA <= 1;
		flags("not pwm", 0);
		fA <= 0;
	endtask : t_fault
	// Mode and clear policy go in while the counter is still held clear,
	// so the run starts from zero and meets the secondary value in time
	task t_trig(input logic [15:0] c1, input logic e);
		vals(0, 2, 3, 16'h0080);
		xf(1, `OCP_OFS_CON1, c1);
		xf(1, `OCP_OFS_CON2, 16'h00DF);
		wt(20);
		xf(0, `OCP_OFS_CON2, 0);
		chk("trig run", rd[6], e);
	endtask : t_trig
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 0;
		t_reset();
		t_base();
		duty(0, 0, 0, 6, 16'h001F, 0);
		duty(0, 5, 3, 6, 16'h001F, 240);
		duty(0, 1, 3, 6, 16'h101F, 180);
		duty(1, 3, 3, 7, 16'h001F, 120);
		t_modes();
		t_idle();
		t_fault();
		t_trig(16'h1C0B, 0);
		t_trig(16'h1C03, 1);
		test_done();
	end
endmodule : output_compare_pwm_channel_tb
`default_nettype wire
